// file: hdl/nvm_seq_pkg.sv
// constants, types and register map of the nvm command sequencer
package nvm_seq_pkg;
  // register byte offsets
  localparam logic [5:0] CLKDIV_OFS = 6'h00;
  localparam logic [5:0] STATUS_OFS = 6'h04;
  localparam logic [5:0] CMD_OFS    = 6'h08;
  localparam logic [5:0] PARAM_OFS  = 6'h0c;
  localparam logic [5:0] DATA0_OFS  = 6'h10;
  localparam logic [5:0] DATA1_OFS  = 6'h14;
  localparam logic [5:0] PROT_OFS   = 6'h18;
  localparam logic [5:0] MARGIN_OFS = 6'h1c;
  // status bit positions
  localparam int ST_COMMAND_COMPLETE_FLAG    = 0;
  localparam int ST_ACCESS_ERROR_FLAG  = 1;
  localparam int ST_FPVIOL  = 2;
  localparam int ST_MGSTAT0 = 3;
  localparam int ST_MGSTAT1 = 4;
  localparam int ST_SECURED = 5;
  localparam int ST_KEYLOCK = 6;
  localparam int ST_DIVLD   = 7;
  // protection bit positions
  localparam int PR_HPD = 0;
  localparam int PR_FPO = 1;
  localparam int PR_EPO = 2;
  // widths and reset values
  localparam int DIV_W = 7;
  localparam int MARGIN_W = 2;
  localparam logic [2:0] PROT_RST = 3'h0;
  localparam logic [15:0] KEY_ZERO = 16'h0000;
  localparam logic [15:0] KEY_ONES = 16'hffff;
  // command codes
  localparam logic [7:0] C_EV_ALL    = 8'h01;
  localparam logic [7:0] C_EV_BLOCK  = 8'h02;
  localparam logic [7:0] C_EV_FSECT  = 8'h03;
  localparam logic [7:0] C_RD_ONCE   = 8'h04;
  localparam logic [7:0] C_PROG_F    = 8'h06;
  localparam logic [7:0] C_PROG_ONCE = 8'h07;
  localparam logic [7:0] C_ERS_ALL   = 8'h08;
  localparam logic [7:0] C_ERS_BLOCK = 8'h09;
  localparam logic [7:0] C_ERS_FSECT = 8'h0a;
  localparam logic [7:0] C_UNSECURE  = 8'h0b;
  localparam logic [7:0] C_KEY_VER   = 8'h0c;
  localparam logic [7:0] C_MARGIN    = 8'h0d;
  localparam logic [7:0] C_EV_ESECT  = 8'h10;
  localparam logic [7:0] C_PROG_E    = 8'h11;
  localparam logic [7:0] C_ERS_ESECT = 8'h12;

  typedef enum logic [1:0] {S_IDLE, S_RUN, S_DONE} state_t;

  // one operation handed to the array macro
  typedef struct packed {
    logic [7:0]  code;
    logic [23:0] addr;
    logic [15:0] count;
    logic [63:0] data;
  } array_op_t;
endpackage

// file: hdl/nvm_command_sequencer.sv
// command decoder and sequencer for the flash and eeprom arrays
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// R01 - code 0x01 checks all flash and eeprom blocks erased
// R02 - code 0x02 checks one selected flash or eeprom block erased
// R03 - code 0x03 checks a counted run of flash words erased
// R04 - code 0x04 returns the 64 byte one-time field
// R05 - code 0x06 programs up to two flash longwords
// R06 - code 0x07 programs the 64 byte field, once only
// R07 - code 0x08 erases everything only with all three protection bits open
// R08 - code 0x09 erases one block only with both flash protection bits open
// R09 - code 0x0a erases one flash sector
// R10 - code 0x0b erases all, verifies, and releases security on success
// R11 - code 0x0c compares keys and releases security on a match
// R12 - code 0x0d sets the user margin read level
// R13 - code 0x10 checks a counted run of eeprom bytes erased
// R14 - code 0x11 programs up to four eeprom bytes
// R15 - code 0x12 erases one eeprom sector
// R16 - flash reads continue during eeprom program or sector erase
// R17 - commander overlaps flash and eeprom work only where allowed
// R18 - accepted commands depend on chip mode and security
// R19 - verified mass erase or unsecure unsecures chip, enables debug port
// R20 - debug host resets, sets divider, opens protection, then erases
// R21 - undefined command code sets access error and is dropped
// R22 - program or erase before divider set sets access error
// R23 - command complete flag sets again when the operation ends
// R24 - after one failed key compare, key commands refused until reset
module nvm_command_sequencer (
  input  wire logic                    clock,
  input  wire logic                    sys_rst,
  input  wire logic [5:0]              address,
  input  wire logic                    read,
  input  wire logic                    write,
  input  wire logic [31:0]             writedata,
  input  wire logic [3:0]              byteenable,
  output logic [31:0]                  readdata,
  output logic                         waitrequest,
  input  wire logic                    special_mode_pin,
  input  wire logic                    secure_strap,
  input  wire logic [63:0]             stored_key,
  output nvm_seq_pkg::array_op_t       array_op,
  output logic                         array_start,
  input  wire logic                    array_done,
  input  wire logic                    array_fail,
  input  wire logic [63:0]             array_rdata,
  output logic                         nvm_tick,
  output logic                         flash_read_ok,
  output logic                         eeprom_read_ok,
  output logic                         debug_enabled,
  output logic [nvm_seq_pkg::MARGIN_W-1:0] margin_level
);
  nvm_seq_pkg::state_t state;
  logic                    ack;
  logic                    mode_meta;
  logic                    mode_sync;
  logic [nvm_seq_pkg::DIV_W-1:0] clkdiv;
  logic [nvm_seq_pkg::DIV_W-1:0] div_cnt;
  logic                    div_loaded;
  logic [31:0]             cmd_reg;
  logic [15:0]             param;
  logic [31:0]             data0;
  logic [31:0]             data1;
  logic [2:0]              prot;
  logic                    access_error_flag;
  logic                    fpviol;
  logic [1:0]              mgstat;
  logic                    secured;
  logic                    key_lock;
  logic                    once_done;

  // bus: one wait state, read data registered in the first cycle
  wire        wr_en   = write & ack;
  wire [31:0] wmask   = {{8{byteenable[3]}}, {8{byteenable[2]}},
                         {8{byteenable[1]}}, {8{byteenable[0]}}};
  wire        wr_div  = wr_en & (address == nvm_seq_pkg::CLKDIV_OFS) & byteenable[0];
  wire        wr_st   = wr_en & (address == nvm_seq_pkg::STATUS_OFS) & byteenable[0];
  wire        wr_cmd  = wr_en & (address == nvm_seq_pkg::CMD_OFS);
  wire        wr_par  = wr_en & (address == nvm_seq_pkg::PARAM_OFS);
  wire        wr_d0   = wr_en & (address == nvm_seq_pkg::DATA0_OFS);
  wire        wr_d1   = wr_en & (address == nvm_seq_pkg::DATA1_OFS);
  wire        wr_prot = wr_en & (address == nvm_seq_pkg::PROT_OFS) & byteenable[0];
  wire        command_complete_flag    = (state == nvm_seq_pkg::S_IDLE);

  wire [31:0] status_word = {24'h0, div_loaded, key_lock, secured, mgstat,
                             fpviol, access_error_flag, command_complete_flag};
  logic [31:0] rd_mux;
  always_comb begin
    unique case (address)
      nvm_seq_pkg::CLKDIV_OFS: rd_mux = {25'h0, clkdiv};
      nvm_seq_pkg::STATUS_OFS: rd_mux = status_word;
      nvm_seq_pkg::CMD_OFS:    rd_mux = cmd_reg;
      nvm_seq_pkg::PARAM_OFS:  rd_mux = {16'h0, param};
      nvm_seq_pkg::DATA0_OFS:  rd_mux = data0;
      nvm_seq_pkg::DATA1_OFS:  rd_mux = data1;
      nvm_seq_pkg::PROT_OFS:   rd_mux = {29'h0, prot};
      nvm_seq_pkg::MARGIN_OFS: rd_mux = {30'h0, margin_level};
      default:                 rd_mux = 32'h0;
    endcase
  end

  assign waitrequest = (read | write) & ~ack;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ack      <= 1'b0;
      readdata <= 32'h0;
    end else begin
      ack <= (read | write) & ~ack;
      if (read & ~ack)
        readdata <= rd_mux;
    end
  end

  // mode pin comes from outside the clock domain
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      mode_meta <= 1'b0;
      mode_sync <= 1'b0;
    end else begin
      mode_meta <= special_mode_pin;
      mode_sync <= mode_meta;
    end
  end

  // command decode
  wire [7:0] code = cmd_reg[7:0];
  wire is_known = (code == nvm_seq_pkg::C_EV_ALL)    | (code == nvm_seq_pkg::C_EV_BLOCK)  |
                  (code == nvm_seq_pkg::C_EV_FSECT)  | (code == nvm_seq_pkg::C_RD_ONCE)   |
                  (code == nvm_seq_pkg::C_PROG_F)    | (code == nvm_seq_pkg::C_PROG_ONCE) |
                  (code == nvm_seq_pkg::C_ERS_ALL)   | (code == nvm_seq_pkg::C_ERS_BLOCK) |
                  (code == nvm_seq_pkg::C_ERS_FSECT) | (code == nvm_seq_pkg::C_UNSECURE)  |
                  (code == nvm_seq_pkg::C_KEY_VER)   | (code == nvm_seq_pkg::C_MARGIN)    |
                  (code == nvm_seq_pkg::C_EV_ESECT)  | (code == nvm_seq_pkg::C_PROG_E)    |
                  (code == nvm_seq_pkg::C_ERS_ESECT);
  wire is_mass = (code == nvm_seq_pkg::C_ERS_ALL) | (code == nvm_seq_pkg::C_UNSECURE);
  wire is_pe   = is_mass | (code == nvm_seq_pkg::C_PROG_F) |
                 (code == nvm_seq_pkg::C_PROG_ONCE) | (code == nvm_seq_pkg::C_ERS_BLOCK) |
                 (code == nvm_seq_pkg::C_ERS_FSECT) | (code == nvm_seq_pkg::C_PROG_E) |
                 (code == nvm_seq_pkg::C_ERS_ESECT);
  wire is_internal = (code == nvm_seq_pkg::C_KEY_VER) | (code == nvm_seq_pkg::C_MARGIN);
  // a secured chip in debug mode may only mass erase, unsecure, verify all or set margin
  wire mode_ok = ~secured | ~mode_sync | is_mass |
                 (code == nvm_seq_pkg::C_EV_ALL) | (code == nvm_seq_pkg::C_MARGIN);  // [R18]
  wire key_refused = (code == nvm_seq_pkg::C_KEY_VER) & key_lock;            // [R24]
  wire once_refused = (code == nvm_seq_pkg::C_PROG_ONCE) & once_done;        // [R06]
  wire bad_cmd = ~is_known | ~mode_ok | key_refused | once_refused |         // [R21]
                 (is_pe & ~div_loaded) | access_error_flag | fpviol;                    // [R22]
  wire prot_bad = ((code == nvm_seq_pkg::C_ERS_ALL) & ~(&prot)) |            // [R07]
                  ((code == nvm_seq_pkg::C_ERS_BLOCK) &
                   ~(prot[nvm_seq_pkg::PR_HPD] & prot[nvm_seq_pkg::PR_FPO])); // [R08]
  wire launch = wr_st & writedata[nvm_seq_pkg::ST_COMMAND_COMPLETE_FLAG] & command_complete_flag;
  wire go     = launch & ~bad_cmd & ~prot_bad;
  wire run_end = (state == nvm_seq_pkg::S_RUN) & array_done;

  // keys of all zeros or all ones never match
  wire keys_legal = (data0[15:0] != nvm_seq_pkg::KEY_ZERO) & (data0[15:0] != nvm_seq_pkg::KEY_ONES) &
                    (data0[31:16] != nvm_seq_pkg::KEY_ZERO) & (data0[31:16] != nvm_seq_pkg::KEY_ONES) &
                    (data1[15:0] != nvm_seq_pkg::KEY_ZERO) & (data1[15:0] != nvm_seq_pkg::KEY_ONES) &
                    (data1[31:16] != nvm_seq_pkg::KEY_ZERO) & (data1[31:16] != nvm_seq_pkg::KEY_ONES);
  wire key_match = keys_legal & ({data1, data0} == stored_key);
  wire key_cmd   = go & (code == nvm_seq_pkg::C_KEY_VER);
  wire mass_ok   = run_end & ~array_fail &
                   ((array_op.code == nvm_seq_pkg::C_ERS_ALL) |
                    (array_op.code == nvm_seq_pkg::C_UNSECURE));
  wire rd_once_end = run_end & (array_op.code == nvm_seq_pkg::C_RD_ONCE);

  // sequencer: array operations wait for done, key and margin finish in a cycle
  always_ff @(posedge clock) begin
    if (sys_rst)
      state <= nvm_seq_pkg::S_IDLE;
    else begin
      unique case (state)
        nvm_seq_pkg::S_IDLE:
          if (go)
            state <= is_internal ? nvm_seq_pkg::S_DONE : nvm_seq_pkg::S_RUN;
        nvm_seq_pkg::S_RUN:
          if (array_done)
            state <= nvm_seq_pkg::S_IDLE;  // [R23]
        nvm_seq_pkg::S_DONE:
          state <= nvm_seq_pkg::S_IDLE;
        default:
          state <= nvm_seq_pkg::S_IDLE;
      endcase
    end
  end

  // operation latched at launch so software cannot disturb it mid-flight;
  // codes other than 0x0c and 0x0d pass straight to the array which does the cell work
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      array_op    <= '0;
      array_start <= 1'b0;
    end else begin
      array_start <= go & ~is_internal;  // [R01] [R02] [R03] [R04] [R05] [R09]
      if (go)
        array_op <= {code, cmd_reg[31:8], param, data1, data0};  // [R13] [R14] [R15]
    end
  end

  // error and result flags; hardware set wins over software clear
  wire clr_acc = wr_st & writedata[nvm_seq_pkg::ST_ACCESS_ERROR_FLAG];
  wire clr_fpv = wr_st & writedata[nvm_seq_pkg::ST_FPVIOL];
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      access_error_flag <= 1'b0;
      fpviol <= 1'b0;
      mgstat <= 2'h0;
    end else begin
      access_error_flag <= (launch & bad_cmd) | (access_error_flag & ~clr_acc);  // [R21] [R22]
      fpviol <= (launch & ~bad_cmd & prot_bad) | (fpviol & ~clr_fpv);  // [R07] [R08]
      if (go)
        mgstat <= 2'h0;
      else if (run_end)
        mgstat <= {2{array_fail}};
    end
  end

  // security is loaded from the strap at reset and released by erase or keys
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      secured   <= secure_strap;
      key_lock  <= 1'b0;
      once_done <= 1'b0;
    end else begin
      if (mass_ok | (key_cmd & key_match))
        secured <= 1'b0;  // [R10] [R11] [R19]
      if (key_cmd & ~key_match)
        key_lock <= 1'b1;  // [R24]
      if (run_end & ~array_fail & (array_op.code == nvm_seq_pkg::C_PROG_ONCE))
        once_done <= 1'b1;  // [R06]
    end
  end
  assign debug_enabled = ~secured;  // [R19]

  // software registers; read-once data lands in the data pair
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      clkdiv       <= '0;
      div_loaded   <= 1'b0;
      cmd_reg      <= 32'h0;
      param        <= 16'h0;
      data0        <= 32'h0;
      data1        <= 32'h0;
      prot         <= nvm_seq_pkg::PROT_RST;
      margin_level <= '0;
    end else begin
      if (wr_div) begin
        clkdiv     <= writedata[nvm_seq_pkg::DIV_W-1:0];
        div_loaded <= 1'b1;
      end
      if (wr_cmd)
        cmd_reg <= (cmd_reg & ~wmask) | (writedata & wmask);
      if (wr_par)
        param <= (param & ~wmask[15:0]) | (writedata[15:0] & wmask[15:0]);
      if (rd_once_end)
        data0 <= array_rdata[31:0];  // [R04]
      else if (wr_d0)
        data0 <= (data0 & ~wmask) | (writedata & wmask);
      if (rd_once_end)
        data1 <= array_rdata[63:32];
      else if (wr_d1)
        data1 <= (data1 & ~wmask) | (writedata & wmask);
      if (wr_prot)
        prot <= writedata[2:0];
      if (go & (code == nvm_seq_pkg::C_MARGIN))
        margin_level <= param[nvm_seq_pkg::MARGIN_W-1:0];  // [R12]
    end
  end

  // array timing tick: divide by clkdiv+1, silent until the divider is set
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      div_cnt  <= '0;
      nvm_tick <= 1'b0;
    end else begin
      nvm_tick <= div_loaded & (div_cnt == clkdiv);
      if (~div_loaded | (div_cnt == clkdiv))
        div_cnt <= '0;
      else
        div_cnt <= div_cnt + 1'b1;
    end
  end

  // the arrays share hardware, so only flash reads survive eeprom writes
  assign flash_read_ok = command_complete_flag |
                         ((state == nvm_seq_pkg::S_RUN) &
                          ((array_op.code == nvm_seq_pkg::C_PROG_E) |
                           (array_op.code == nvm_seq_pkg::C_ERS_ESECT)));  // [R16]
  assign eeprom_read_ok = command_complete_flag;

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  sequence s_launch_bad;
    launch && ~is_known;
  endsequence
  sequence s_run_finish;
    (state == nvm_seq_pkg::S_RUN) ##0 array_done;
  endsequence

  bus_wait_a: assert property ((read && waitrequest) |=> !waitrequest)
    else $error("read not answered after one wait state");
  undef_code_a: assert property (s_launch_bad |=> access_error_flag && command_complete_flag && !array_start)  // [R21]
    else $error("undefined code was not refused");
  div_unset_a: assert property (launch && is_pe && !div_loaded |=> access_error_flag && !array_start)  // [R22]
    else $error("program or erase started without divider");
  mass_prot_a: assert property (launch && !bad_cmd && code == nvm_seq_pkg::C_ERS_ALL
                                && !(&prot) |=> fpviol && command_complete_flag)  // [R07]
    else $error("erase all ran with protection closed");
  block_prot_a: assert property (launch && !bad_cmd && code == nvm_seq_pkg::C_ERS_BLOCK
                                 && !prot[nvm_seq_pkg::PR_FPO] |=> fpviol && !array_start)  // [R08]
    else $error("block erase ran with protection closed");
  run_done_a: assert property (s_run_finish |=> command_complete_flag)  // [R23]
    else $error("complete flag not set after operation");
  start_run_a: assert property (go && !is_internal |=> array_start && !command_complete_flag ##1 !array_start)
    else $error("array start not a single pulse after launch");
  unsecure_a: assert property (mass_ok |=> !secured && debug_enabled)  // [R19]
    else $error("verified mass erase did not unsecure");
  key_fail_a: assert property (key_cmd && !key_match |=> key_lock [*2])  // [R24]
    else $error("key lock not held after failed compare");
  rww_a: assert property ((state == nvm_seq_pkg::S_RUN)
                          && array_op.code == nvm_seq_pkg::C_PROG_E |-> flash_read_ok)  // [R16]
    else $error("flash read blocked during eeprom program");
endmodule
`default_nettype wire

// file: verif/nvm_array_model.sv
// behavioural array macro answering the sequencer's operations
`timescale 1ns/1ps
`default_nettype none
module nvm_array_model #(
  parameter logic [63:0] ONCE_DATA = 64'h0123_4567_89ab_cdef
) (
  input  wire logic                   clock,
  input  wire logic                   sys_rst,
  input  wire logic                   array_start,
  input  wire nvm_seq_pkg::array_op_t array_op,
  input  wire logic                   fail_next,
  input  wire logic                   slow,
  output logic                        array_done,
  output logic                        array_fail,
  output logic [63:0]                 array_rdata
);
  logic [5:0]  remain;
  logic        busy;
  logic        fail_q;
  logic [63:0] noise;
  // outside the done pulse the answer lines carry a moving pattern, never the last value
  assign array_fail  = array_done ? fail_q : noise[0];
  // only a read-once answer carries the stored field
  assign array_rdata = (array_done && array_op.code == nvm_seq_pkg::C_RD_ONCE) ? ONCE_DATA :
                       noise;
  always_ff @(posedge clock) begin
    array_done <= 1'b0;
    if (sys_rst) begin
      noise <= 64'h5a5a_0f0f_3c3c_9696;
      busy <= 1'b0;
      remain <= 6'h00;
    end else begin
      noise <= {noise[62:0], ~noise[63]};
      if (array_start && !busy) begin
        // one operation at a time: the arrays share pump and sense logic
        busy <= 1'b1;
        remain <= slow ? 6'h14 : 6'h01;
        fail_q <= fail_next;
      end else if (busy) begin
        remain <= remain - 6'h01;
        if (remain == 6'h01) begin
          busy <= 1'b0;
          array_done <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: verif/tb_top.sv
// self-checking testbench of the nvm command sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [63:0] ONCE = 64'h0123_4567_89ab_cdef;
  localparam logic [63:0] KEY  = 64'h1234_5678_9abc_def0;
  logic        clock, sys_rst, read, write, waitrequest, special_mode_pin, secure_strap;
  logic [5:0]  address;
  logic [31:0] writedata, readdata;
  logic        array_start, array_done, array_fail, fail_next, slow;
  logic [63:0] array_rdata;
  logic        nvm_tick, flash_read_ok, eeprom_read_ok, debug_enabled;
  logic [1:0]  margin_level;
  logic [7:0]  last_code;
  nvm_seq_pkg::array_op_t array_op;
  int          errors, n_tests, starts;

  nvm_command_sequencer dut (.clock(clock), .sys_rst(sys_rst), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(4'hf),
    .readdata(readdata), .waitrequest(waitrequest), .special_mode_pin(special_mode_pin),
    .secure_strap(secure_strap), .stored_key(KEY), .array_op(array_op),
    .array_start(array_start), .array_done(array_done), .array_fail(array_fail),
    .array_rdata(array_rdata), .nvm_tick(nvm_tick), .flash_read_ok(flash_read_ok),
    .eeprom_read_ok(eeprom_read_ok), .debug_enabled(debug_enabled),
    .margin_level(margin_level));
  nvm_array_model #(.ONCE_DATA(ONCE)) far (.clock(clock), .sys_rst(sys_rst),
    .array_start(array_start), .array_op(array_op), .fail_next(fail_next), .slow(slow),
    .array_done(array_done), .array_fail(array_fail), .array_rdata(array_rdata));

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  always @(posedge clock) begin
    if (array_start === 1'b1) begin
      starts <= starts + 1;
      last_code <= array_op.code;
    end
  end

  task automatic test_done();
    $display("errors %0d n_tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic fail_now(input string m);
    errors++;
    $display("mismatch at %0t: %s", $time, m);
    test_done();
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask
  function automatic logic [31:0] b(input int n);
    return 32'h1 << n;
  endfunction

  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clock);
    address <= a;
    writedata <= d;
    write <= w;
    read <= ~w;
    q = 32'h0;
    // waitrequest and readdata are taken at the rising edge, before it updates them
    for (int i = 0; i < 20; i++) begin
      @(posedge clock);
      if (waitrequest === 1'b0) begin
        q = readdata;
        write <= 1'b0;
        read <= 1'b0;
        return;
      end
    end
    fail_now("bus hang");
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic st(input logic [31:0] mask, input logic [31:0] exp, input string m);
    logic [31:0] s;
    bus(1'b0, nvm_seq_pkg::STATUS_OFS, 32'h0, s);
    check(s & mask, exp, m);
  endtask
  task automatic ticks(input logic [31:0] exp, input string m);
    logic [31:0] k;
    k = 32'h0;
    repeat (20) begin
      @(posedge clock);
      if (nvm_tick === 1'b1) k++;
    end
    check(k, exp, m);
  endtask
  task automatic idle();
    logic [31:0] s;
    for (int i = 0; i < 60; i++) begin
      bus(1'b0, nvm_seq_pkg::STATUS_OFS, 32'h0, s);
      if (s[nvm_seq_pkg::ST_COMMAND_COMPLETE_FLAG] === 1'b1) return;
    end
    fail_now("no completion");
  endtask
  task automatic launch(input logic [7:0] c, input logic [15:0] p, input logic w);
    wr(nvm_seq_pkg::CMD_OFS, {24'h000100, c});
    wr(nvm_seq_pkg::PARAM_OFS, {16'h0000, p});
    wr(nvm_seq_pkg::STATUS_OFS, 32'h1);
    if (w) idle();
  endtask
  task automatic do_reset(input logic mode);
    special_mode_pin <= mode;
    sys_rst <= 1'b1;
    repeat (8) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clock);
  endtask

  task automatic t_start();
    logic [31:0] q;
    st(b(0) | b(5) | b(7), b(0) | b(5), "reset status");
    check(debug_enabled, 1'b0, "debug port while secured");
    bus(1'b0, 6'h20, 32'h0, q);
    check(q, 32'h0, "unmapped read");
    ticks(32'h0, "no tick before divider");
  endtask
  task automatic t_nodiv();
    int n;
    n = starts;
    launch(nvm_seq_pkg::C_PROG_F, 16'h1, 1'b1);
    st(b(1), b(1), "program before divider");
    check(32'(starts - n), 32'h0, "no array start");
    wr(nvm_seq_pkg::STATUS_OFS, 32'h6);
    wr(nvm_seq_pkg::CLKDIV_OFS, 32'h3);
    ticks(32'h4, "tick every fourth cycle");
    launch(8'h05, 16'h1, 1'b1);
    st(b(1), b(1), "undefined code");
    check(32'(starts - n), 32'h0, "undefined code dropped");
    wr(nvm_seq_pkg::STATUS_OFS, 32'h6);
  endtask
  task automatic t_codes();
    logic [7:0]  cs [10] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h06, 8'h07, 8'h0a, 8'h10,
                             8'h11, 8'h12};
    logic [31:0] q;
    int          n;
    for (int i = 0; i < 10; i++) begin
      n = starts;
      launch(cs[i], 16'(i + 1), 1'b1);
      check(32'(starts - n), 32'h1, "one array start");
      check(32'(last_code), 32'(cs[i]), "code sent");
      st(b(1) | b(2) | b(3), 32'h0, "clean finish");
      if (cs[i] == nvm_seq_pkg::C_RD_ONCE) begin
        bus(1'b0, nvm_seq_pkg::DATA0_OFS, 32'h0, q);
        check(q, ONCE[31:0], "read-once low");
        bus(1'b0, nvm_seq_pkg::DATA1_OFS, 32'h0, q);
        check(q, ONCE[63:32], "read-once high");
      end
    end
    launch(nvm_seq_pkg::C_PROG_ONCE, 16'h1, 1'b1);
    st(b(1), b(1), "second program-once");
    wr(nvm_seq_pkg::STATUS_OFS, 32'h6);
  endtask
  task automatic t_misc();
    logic [31:0] s;
    slow <= 1'b1;
    launch(nvm_seq_pkg::C_PROG_E, 16'h1, 1'b0);
    bus(1'b0, nvm_seq_pkg::STATUS_OFS, 32'h0, s);
    check(32'(s[0]), 32'h0, "eeprom program busy");
    check({flash_read_ok, eeprom_read_ok}, 2'b10, "flash read during eeprom write");
    idle();
    slow <= 1'b0;
    fail_next <= 1'b1;
    launch(nvm_seq_pkg::C_EV_ALL, 16'h1, 1'b1);
    st(b(3) | b(4), b(3) | b(4), "blank check fail");
    fail_next <= 1'b0;
    launch(nvm_seq_pkg::C_MARGIN, 16'h2, 1'b1);
    check(margin_level, 2'h2, "margin level");
  endtask
  task automatic t_key_mass();
    int n;
    wr(nvm_seq_pkg::DATA0_OFS, KEY[31:0] ^ 32'h1);
    wr(nvm_seq_pkg::DATA1_OFS, KEY[63:32]);
    launch(nvm_seq_pkg::C_KEY_VER, 16'h0, 1'b1);
    st(b(5) | b(6), b(5) | b(6), "bad key locks");
    wr(nvm_seq_pkg::DATA0_OFS, KEY[31:0]);
    launch(nvm_seq_pkg::C_KEY_VER, 16'h0, 1'b1);
    st(b(1) | b(5), b(1) | b(5), "key refused after lock");
    wr(nvm_seq_pkg::STATUS_OFS, 32'h6);
    n = starts;
    launch(nvm_seq_pkg::C_ERS_BLOCK, 16'h0, 1'b1);
    st(b(2), b(2), "block erase protected");
    wr(nvm_seq_pkg::STATUS_OFS, 32'h6);
    wr(nvm_seq_pkg::PROT_OFS, 32'h3);
    launch(nvm_seq_pkg::C_ERS_ALL, 16'h0, 1'b1);
    st(b(2), b(2), "mass erase protected");
    check(32'(starts - n), 32'h0, "mass erase dropped");
    wr(nvm_seq_pkg::STATUS_OFS, 32'h6);
    launch(nvm_seq_pkg::C_ERS_BLOCK, 16'h0, 1'b1);
    st(b(2) | b(5), b(5), "block erase open");
    wr(nvm_seq_pkg::PROT_OFS, 32'h7);
    launch(nvm_seq_pkg::C_ERS_ALL, 16'h0, 1'b1);
    st(b(2) | b(5), 32'h0, "mass erase unsecures");
    check(debug_enabled, 1'b1, "debug port opened");
  endtask
  task automatic t_key_good();
    wr(nvm_seq_pkg::DATA0_OFS, KEY[31:0]);
    wr(nvm_seq_pkg::DATA1_OFS, KEY[63:32]);
    launch(nvm_seq_pkg::C_KEY_VER, 16'h0, 1'b1);
    st(b(1) | b(5) | b(6), 32'h0, "good key unsecures");
  endtask
  task automatic t_mode();
    wr(nvm_seq_pkg::CLKDIV_OFS, 32'h3);
    launch(nvm_seq_pkg::C_EV_BLOCK, 16'h0, 1'b1);
    st(b(1), b(1), "secured special mode refuses");
    wr(nvm_seq_pkg::STATUS_OFS, 32'h6);
    wr(nvm_seq_pkg::PROT_OFS, 32'h7);
    launch(nvm_seq_pkg::C_UNSECURE, 16'h0, 1'b1);
    st(b(1) | b(5), 32'h0, "unsecure command");
    check(debug_enabled, 1'b1, "debug port after unsecure");
  endtask

  initial begin
    errors = 0;
    n_tests = 0;
    starts = 0;
    sys_rst = 1'b1;
    read = 1'b0;
    write = 1'b0;
    address = 6'h00;
    writedata = 32'h0;
    special_mode_pin = 1'b0;
    secure_strap = 1'b1;
    fail_next = 1'b0;
    slow = 1'b0;
    do_reset(1'b0);
    t_start();
    t_nodiv();
    t_codes();
    t_misc();
    t_key_mass();
    do_reset(1'b0);
    t_key_good();
    do_reset(1'b1);
    t_mode();
    test_done();
  end
  initial begin
    repeat (100000) @(posedge clock);
    fail_now("run too long");
  end
endmodule
`default_nettype wire
